// ---- common/bps_map.vh ----
// Constants for the boot processor select block
`ifndef BPS_MAP_VH
`define BPS_MAP_VH

// ==========================================================
// Clock and timing: one minute of hang at 10 MHz
`define BPS_HANG_CYC 30'h23c34600
`define BPS_HANG_W 30
`define BPS_SETTLE_CYC 8'h20
`define BPS_SETTLE_W 8

// ==========================================================
// Register byte addresses
`define BPS_A_CTRL 4'h0
`define BPS_A_STATUS 4'h4
`define BPS_A_IRQ_ST 4'h8
`define BPS_A_IRQ_MASK 4'hc

// ==========================================================
// Control register fields
`define BPS_C_ELIG 0
`define BPS_C_OVR_EN 1
`define BPS_C_OVR_LO 4
`define BPS_C_OVR_HI 7
`define BPS_CTRL_RST 8'h01

// ==========================================================
// Status register fields
`define BPS_S_STATE_HI 8
`define BPS_S_ST_PASS 9
`define BPS_S_ET_PASS 10
`define BPS_S_PROV_V 11
`define BPS_S_PROV_LO 12
`define BPS_S_FIN_V 16
`define BPS_S_FIN_LO 17
`define BPS_S_BOOT 21
`define BPS_S_IO_DONE 22
`define BPS_S_IO_PASS 23

// ==========================================================
// Interrupt events
`define BPS_IRQ_W 5
`define BPS_EV_PROV 0
`define BPS_EV_FINAL 1
`define BPS_EV_RESEL 2
`define BPS_EV_HANG 3
`define BPS_EV_BOOT 4

`define BPS_NODES 16
`define BPS_RED_PASS 8'hc0
`define BPS_RED_SEC 8'h01

`endif

// ---- src/bps_pick.v ----
// Lowest-numbered candidate finder with an explicit override
`timescale 1ns/1ps
module bps_pick (
    cand,
    ovr_en,
    ovr_node,
    found,
    node
);
    input wire [15:0] cand;
    input wire ovr_en;
    input wire [3:0] ovr_node;
    output reg found;
    output reg [3:0] node;
    integer i;
    always @* begin
        found = 1'b0;
        node = 4'h0;
        // Scan downward so the lowest set bit is the last one taken
        for (i = 15; i >= 0; i = i - 1) begin
            if (cand[i]) begin
                found = 1'b1;
                node = i[3:0];
            end
        end
        // Explicit choice wins only if that node is itself a candidate
        if (ovr_en && cand[ovr_node]) begin
            found = 1'b1;
            node = ovr_node;
        end
    end
endmodule

// ---- src/bps_timer.v ----
// Restartable up-counter that flags when its limit is reached
`timescale 1ns/1ps
module bps_timer #(
    parameter WIDTH = 8,
    parameter [WIDTH-1:0] LIMIT = {{(WIDTH-1){1'b0}}, 1'b1}
) (
    clk,
    rst_n,
    restart,
    expired
);
    input wire clk;
    input wire rst_n;
    input wire restart;
    output wire expired;
    reg [WIDTH-1:0] count;
    assign expired = (count == LIMIT);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= {WIDTH{1'b0}};
        end else if (restart) begin
            count <= {WIDTH{1'b0}};
        end else if (!expired) begin
            count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule

// ---- src/bps_top.v ----
// Power-up sequencer and boot processor selection for one node
`timescale 1ns/1ps
`include "bps_map.vh"
// Contract
// - Run local self-test at power-up, publish pass bit on shared line.
// - Choose boot processor automatically, all others are secondaries.
// - Default choice is the lowest node number.
// - Skip failing nodes, take next higher passing node.
// - Ineligible nodes never chosen; explicit choice overrides automatic. The hang force takes op_force_node without an eligibility check.
// - Provisional boot node signals start; extended test waits for it.
// - Record extended-test pass bit separately from self-test.
// - Reselect if provisional fails extended test; report final separately.
// - Passing node lights yellow, top two red; bottom red on secondaries.
// - No boot node: no results, yellow off, red shows failing test BCD.
// - In hang, after timeout, operator node request makes that boot node.
// - Boot on console request or reset with auto-start key set.
// - Only the final boot node tests the I/O adapter.
// - Boot node copies changed parameters to secondaries except hidden ones.
module bps_top #(
    parameter [`BPS_HANG_W-1:0] HANG_CYCLES = `BPS_HANG_CYC
) (
    clk,
    rst_b,
    node_id,
    bus_addr,
    bus_wdata,
    bus_wr,
    bus_rd,
    bus_rdata,
    irq,
    self_test_start,
    self_test_done,
    self_test_pass,
    ext_test_start,
    ext_test_done,
    ext_test_pass,
    self_test_result_line_in,
    self_test_result_line_out,
    extended_test_result_line_in,
    extended_test_result_line_out,
    elig_line_in,
    elig_line_out,
    start_line_in,
    start_line_out,
    boot_choice_line_out,
    results_valid,
    fail_test_bcd,
    yellow_led,
    red_led,
    op_force_valid,
    op_force_node,
    console_prompt,
    console_boot_req,
    auto_start_key,
    boot_start,
    io_test_start,
    io_test_done,
    io_test_pass,
    nv_changed,
    nv_hidden,
    nv_copy_start
);
    input wire clk;
    input wire rst_b;
    input wire [3:0] node_id;
    input wire [3:0] bus_addr;
    input wire [31:0] bus_wdata;
    input wire bus_wr;
    input wire bus_rd;
    output reg [31:0] bus_rdata;
    output wire irq;
    output reg self_test_start;
    input wire self_test_done;
    input wire self_test_pass;
    output reg ext_test_start;
    input wire ext_test_done;
    input wire ext_test_pass;
    input wire [15:0] self_test_result_line_in;
    output reg self_test_result_line_out;
    input wire [15:0] extended_test_result_line_in;
    output reg extended_test_result_line_out;
    input wire [15:0] elig_line_in;
    output wire elig_line_out;
    input wire start_line_in;
    output reg start_line_out;
    output reg boot_choice_line_out;
    output reg results_valid;
    input wire [7:0] fail_test_bcd;
    output reg yellow_led;
    output reg [7:0] red_led;
    input wire op_force_valid;
    input wire [3:0] op_force_node;
    output reg console_prompt;
    input wire console_boot_req;
    input wire auto_start_key;
    output reg boot_start;
    output reg io_test_start;
    input wire io_test_done;
    input wire io_test_pass;
    input wire nv_changed;
    input wire nv_hidden;
    output reg nv_copy_start;

    // ======================================================
    // Reset release
    reg [1:0] rst_pipe;
    wire rst_n;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_pipe <= 2'b00;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // ======================================================
    // States
    localparam [8:0] S_SELF = 9'h001;
    localparam [8:0] S_SET1 = 9'h002;
    localparam [8:0] S_SEL1 = 9'h004;
    localparam [8:0] S_WSTART = 9'h008;
    localparam [8:0] S_EXT = 9'h010;
    localparam [8:0] S_SET2 = 9'h020;
    localparam [8:0] S_SEL2 = 9'h040;
    localparam [8:0] S_RUN = 9'h080;
    localparam [8:0] S_HANG = 9'h100;

    reg [8:0] state;
    reg [7:0] ctrl;
    reg [`BPS_IRQ_W-1:0] irq_st;
    reg [`BPS_IRQ_W-1:0] irq_mask;
    reg [`BPS_IRQ_W-1:0] ev;
    reg powered;
    reg [3:0] my_node;
    reg auto_armed;
    reg st_pass;
    reg et_pass;
    reg prov_v;
    reg [3:0] prov_node;
    reg fin_v;
    reg [3:0] fin_node;
    reg io_done_seen;
    reg io_pass;
    reg settle_restart;
    wire settle_done;
    wire hang_done;
    wire found1;
    wire found2;
    wire [3:0] pick1;
    wire [3:0] pick2;
    wire [15:0] cand1;
    wire [15:0] cand2;
    wire is_boot;

    assign elig_line_out = ctrl[`BPS_C_ELIG];
    assign cand1 = self_test_result_line_in & elig_line_in;
    assign cand2 = cand1 & extended_test_result_line_in;
    assign is_boot = fin_v && (fin_node == my_node);
    assign irq = |(irq_st & irq_mask);

    // ======================================================
    // Selection and timers
    bps_pick u_pick1 (
        .cand(cand1),
        .ovr_en(ctrl[`BPS_C_OVR_EN]),
        .ovr_node(ctrl[`BPS_C_OVR_HI:`BPS_C_OVR_LO]),
        .found(found1),
        .node(pick1)
    );
    bps_pick u_pick2 (
        .cand(cand2),
        .ovr_en(ctrl[`BPS_C_OVR_EN]),
        .ovr_node(ctrl[`BPS_C_OVR_HI:`BPS_C_OVR_LO]),
        .found(found2),
        .node(pick2)
    );
    // Peers report at their own pace; a settle window lets slower
    // nodes publish before the choice is frozen
    bps_timer #(
        .WIDTH(`BPS_SETTLE_W),
        .LIMIT(`BPS_SETTLE_CYC)
    ) u_settle (
        .clk(clk),
        .rst_n(rst_n),
        .restart(settle_restart),
        .expired(settle_done)
    );
    // Runs once from power-up, not from hang entry
    bps_timer #(
        .WIDTH(`BPS_HANG_W),
        .LIMIT(HANG_CYCLES)
    ) u_hang (
        .clk(clk),
        .rst_n(rst_n),
        .restart(!powered),
        .expired(hang_done)
    );

    // ======================================================
    // Sequencer
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_SELF;
            powered <= 1'b0;
            my_node <= 4'h0;
            auto_armed <= 1'b0;
            st_pass <= 1'b0;
            et_pass <= 1'b0;
            prov_v <= 1'b0;
            prov_node <= 4'h0;
            fin_v <= 1'b0;
            fin_node <= 4'h0;
            io_done_seen <= 1'b0;
            io_pass <= 1'b0;
            settle_restart <= 1'b0;
            self_test_start <= 1'b0;
            ext_test_start <= 1'b0;
            start_line_out <= 1'b0;
            io_test_start <= 1'b0;
            boot_start <= 1'b0;
            nv_copy_start <= 1'b0;
            self_test_result_line_out <= 1'b0;
            extended_test_result_line_out <= 1'b0;
            ev <= {`BPS_IRQ_W{1'b0}};
        end else begin
            self_test_start <= 1'b0;
            ext_test_start <= 1'b0;
            start_line_out <= 1'b0;
            io_test_start <= 1'b0;
            boot_start <= 1'b0;
            nv_copy_start <= 1'b0;
            settle_restart <= 1'b0;
            ev <= {`BPS_IRQ_W{1'b0}};
            if (!powered) begin
                // Straps caught on the first edge after release
                powered <= 1'b1;
                my_node <= node_id;
                auto_armed <= auto_start_key;
                self_test_start <= 1'b1;
            end
            case (state)
                S_SELF: begin
                    if (powered && self_test_done) begin
                        st_pass <= self_test_pass;
                        self_test_result_line_out <= self_test_pass;
                        settle_restart <= 1'b1;
                        state <= S_SET1;
                    end
                end
                S_SET1: begin
                    if (settle_done && !settle_restart) begin
                        state <= S_SEL1;
                    end
                end
                S_SEL1: begin
                    if (found1) begin
                        prov_v <= 1'b1;
                        prov_node <= pick1;
                        ev[`BPS_EV_PROV] <= 1'b1;
                        start_line_out <= (pick1 == my_node);
                        state <= S_WSTART;
                    end else begin
                        ev[`BPS_EV_HANG] <= 1'b1;
                        state <= S_HANG;
                    end
                end
                S_WSTART: begin
                    if (start_line_in) begin
                        ext_test_start <= 1'b1;
                        state <= S_EXT;
                    end
                end
                S_EXT: begin
                    if (ext_test_done) begin
                        et_pass <= ext_test_pass;
                        extended_test_result_line_out <= ext_test_pass;
                        settle_restart <= 1'b1;
                        state <= S_SET2;
                    end
                end
                S_SET2: begin
                    if (settle_done && !settle_restart) begin
                        state <= S_SEL2;
                    end
                end
                S_SEL2: begin
                    if (found2) begin
                        fin_v <= 1'b1;
                        fin_node <= pick2;
                        ev[`BPS_EV_FINAL] <= 1'b1;
                        ev[`BPS_EV_RESEL] <= (pick2 != prov_node);
                        io_test_start <= (pick2 == my_node);
                        state <= S_RUN;
                    end else begin
                        ev[`BPS_EV_HANG] <= 1'b1;
                        state <= S_HANG;
                    end
                end
                S_HANG: begin
                    if (hang_done && op_force_valid) begin
                        fin_v <= 1'b1;
                        fin_node <= op_force_node;
                        ev[`BPS_EV_FINAL] <= 1'b1;
                        io_test_start <= (op_force_node == my_node);
                        state <= S_RUN;
                    end
                end
                S_RUN: begin
                    if (is_boot && io_test_done && !io_done_seen) begin
                        io_done_seen <= 1'b1;
                        io_pass <= io_test_pass;
                    end
                    // Auto-start waits for the adapter test to finish
                    if (is_boot && (console_boot_req ||
                        (auto_armed && io_done_seen))) begin
                        boot_start <= 1'b1;
                        auto_armed <= 1'b0;
                        ev[`BPS_EV_BOOT] <= 1'b1;
                    end
                    if (is_boot && nv_changed && !nv_hidden) begin
                        nv_copy_start <= 1'b1;
                    end
                end
                default: begin
                    state <= S_SELF;
                end
            endcase
        end
    end

    // ======================================================
    // Indicators and reporting
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            yellow_led <= 1'b0;
            red_led <= 8'h00;
            results_valid <= 1'b0;
            boot_choice_line_out <= 1'b0;
            console_prompt <= 1'b0;
        end else begin
            boot_choice_line_out <= is_boot;
            console_prompt <= is_boot && (state == S_RUN);
            if (state == S_HANG) begin
                yellow_led <= 1'b0;
                red_led <= fail_test_bcd;
                results_valid <= 1'b0;
            end else if (fin_v && st_pass && et_pass) begin
                yellow_led <= 1'b1;
                red_led <= is_boot ? `BPS_RED_PASS :
                    (`BPS_RED_PASS | `BPS_RED_SEC);
                results_valid <= is_boot;
            end else begin
                yellow_led <= 1'b0;
                red_led <= 8'h00;
                results_valid <= is_boot;
            end
        end
    end

    // ======================================================
    // Register port
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `BPS_CTRL_RST;
            irq_mask <= {`BPS_IRQ_W{1'b0}};
            irq_st <= {`BPS_IRQ_W{1'b0}};
            bus_rdata <= 32'h0000_0000;
        end else begin
            if (bus_wr && bus_addr == `BPS_A_CTRL) begin
                ctrl <= bus_wdata[7:0];
            end
            if (bus_wr && bus_addr == `BPS_A_IRQ_MASK) begin
                irq_mask <= bus_wdata[`BPS_IRQ_W-1:0];
            end
            // A new event outranks a clear in the same cycle
            if (bus_wr && bus_addr == `BPS_A_IRQ_ST) begin
                irq_st <= (irq_st & ~bus_wdata[`BPS_IRQ_W-1:0]) | ev;
            end else begin
                irq_st <= irq_st | ev;
            end
            bus_rdata <= 32'h0000_0000;
            if (bus_rd) begin
                case (bus_addr)
                    `BPS_A_CTRL: bus_rdata <= {24'h000000, ctrl};
                    `BPS_A_STATUS: begin
                        bus_rdata <= {8'h00, io_pass, io_done_seen,
                            is_boot, fin_node, fin_v, prov_node,
                            prov_v, et_pass, st_pass, state};
                    end
                    `BPS_A_IRQ_ST: bus_rdata <= {27'h0, irq_st};
                    `BPS_A_IRQ_MASK: bus_rdata <= {27'h0, irq_mask};
                    default: bus_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

// ---- tb/bps_top_chk.sv ----
// Assertion checker for the boot processor select block
`timescale 1ns/1ps
module bps_chk (
    input wire clk,
    input wire rst_b,
    input wire self_test_done,
    input wire self_test_pass,
    input wire self_test_result_line_out,
    input wire ext_test_done,
    input wire ext_test_pass,
    input wire ext_test_start,
    input wire extended_test_result_line_out,
    input wire start_line_in,
    input wire start_line_out,
    input wire elig_line_out,
    input wire boot_choice_line_out,
    input wire op_force_valid,
    input wire yellow_led,
    input wire [7:0] red_led,
    input wire [7:0] fail_test_bcd,
    input wire results_valid,
    input wire console_boot_req,
    input wire console_prompt,
    input wire boot_start,
    input wire nv_changed,
    input wire nv_hidden,
    input wire nv_copy_start,
    input wire io_test_start
);
    logic forced;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // ==========================================================
    // Helper: a forced choice skips the pass and eligibility gate
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            forced <= 1'b0;
        else if (op_force_valid)
            forced <= 1'b1;
    end
    sequence s_et_ok;
        ext_test_done && ext_test_pass;
    endsequence
    // ==========================================================
    // Assertions
    a_st_line_cause: assert property ($rose(self_test_result_line_out)
        |-> $past(self_test_done && self_test_pass))
        else $error("self-test line rose without a passing result");
    a_et_line_set: assert property (s_et_ok |=>
        extended_test_result_line_out)
        else $error("extended-test line not set after a pass");
    a_ext_after_start: assert property ($rose(ext_test_start)
        |-> $past(start_line_in))
        else $error("extended test began without the start signal");
    a_start_from_cand: assert property (start_line_out
        |-> self_test_result_line_out && elig_line_out)
        else $error("start sent by a node that is no candidate");
    a_final_is_cand: assert property ($rose(boot_choice_line_out)
        && !forced |-> self_test_result_line_out
        && extended_test_result_line_out && elig_line_out)
        else $error("final boot node is not a passing eligible node");
    a_bottom_red_led: assert property (yellow_led
        |-> red_led == (boot_choice_line_out ? 8'hc0 : 8'hc1))
        else $error("led pattern wrong for a passing node");
    a_hang_led_code: assert property (!yellow_led && red_led != 8'h00
        |-> red_led == $past(fail_test_bcd) && !results_valid)
        else $error("hang leds do not show the failing test");
    a_boot_on_req: assert property (console_boot_req && console_prompt
        |=> boot_start)
        else $error("boot request gave no boot start");
    a_nv_copy_rule: assert property (nv_changed && console_prompt
        |=> nv_copy_start == !$past(nv_hidden))
        else $error("parameter copy wrong for hidden flag");
    a_io_boot_only: assert property (io_test_start
        |-> ##[0:1] boot_choice_line_out)
        else $error("adapter test started on a secondary");
endmodule
bind bps_top bps_chk bps_chk_i (.*);

// ---- tb/bps_peers.sv ----
// Behavioural model of the peer processor modules on the shared lines
`timescale 1ns/1ps
module bps_peers (
    input wire logic clk,
    input wire logic go,
    input wire logic [3:0] node_id,
    input wire logic own_st,
    input wire logic own_et,
    input wire logic own_elig,
    input wire logic own_start,
    input wire logic [15:0] st_mask,
    input wire logic [15:0] et_mask,
    input wire logic [15:0] el_mask,
    input wire logic [7:0] delay,
    output wire logic [15:0] st_line,
    output wire logic [15:0] et_line,
    output wire logic [15:0] el_line,
    output wire logic start_line
);
    logic [15:0] own;
    logic [15:0] cand;
    logic [7:0] cnt = 8'h00;
    logic sent = 1'b0;
    logic peer_start = 1'b0;
    logic peer_prov;
    assign own = 16'h0001 << node_id;
    // Empty slots are pulled low, so they read as failed and ineligible
    assign st_line = (st_mask & ~own) | (own_st ? own : 16'h0000);
    assign et_line = (et_mask & ~own) | (own_et ? own : 16'h0000);
    assign el_line = (el_mask & ~own) | (own_elig ? own : 16'h0000);
    assign cand = st_line & el_line;
    assign peer_prov = cand != 16'h0000 &&
        (cand & (~cand + 16'h0001)) != own;
    // Wired start line: any provisional boot node may pulse it
    assign start_line = own_start | peer_start;
    // A slow peer: it reports only after delay cycles
    always @(posedge clk) begin
        peer_start <= 1'b0;
        if (!go) begin
            cnt <= 8'h00;
            sent <= 1'b0;
        end else if (peer_prov && !sent) begin
            cnt <= cnt + 8'h01;
            if (cnt == delay) begin
                peer_start <= 1'b1;
                sent <= 1'b1;
            end
        end
    end
endmodule

// ---- tb/tb.sv ----
// Self-checking testbench for the boot processor select block
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0, rst_b = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
    logic [3:0] node_id = 4'h0, bus_addr = 4'h0, op_force_node = 4'h0;
    logic [31:0] bus_wdata = 32'h0, bus_rdata;
    logic self_test_done = 1'b0, self_test_pass = 1'b0;
    logic ext_test_done = 1'b0, ext_test_pass = 1'b0;
    logic io_test_done = 1'b0, io_test_pass = 1'b1;
    logic op_force_valid = 1'b0, console_boot_req = 1'b0;
    logic auto_start_key = 1'b0, nv_changed = 1'b0, nv_hidden = 1'b0;
    logic [7:0] fail_test_bcd = 8'h42, red_led, delay = 8'h3c;
    logic [15:0] st_mask = 16'h0, et_mask = 16'h0, el_mask = 16'h0;
    logic [15:0] self_test_result_line_in, extended_test_result_line_in;
    logic [15:0] elig_line_in;
    logic irq, self_test_start, ext_test_start, self_test_result_line_out;
    logic extended_test_result_line_out, elig_line_out, start_line_in;
    logic start_line_out, boot_choice_line_out, results_valid, yellow_led;
    logic console_prompt, boot_start, io_test_start, nv_copy_start;
    logic st_ok = 1'b0, et_ok = 1'b0, go = 1'b0;
    int failures = 0, n_checks = 0;

    bps_top #(.HANG_CYCLES(30'h12c)) bps_top_i (.*);
    bps_peers bps_peers_i (.clk(clk), .go(go), .node_id(node_id),
        .own_st(self_test_result_line_out),
        .own_et(extended_test_result_line_out), .own_elig(elig_line_out),
        .own_start(start_line_out), .st_mask(st_mask), .et_mask(et_mask),
        .el_mask(el_mask), .delay(delay),
        .st_line(self_test_result_line_in),
        .et_line(extended_test_result_line_in), .el_line(elig_line_in),
        .start_line(start_line_in));

    always #50 clk = ~clk;
    // ==========================================================
    // Local test engines answer one cycle after each start pulse
    always @(posedge clk) begin
        self_test_done <= self_test_start;
        self_test_pass <= self_test_start & st_ok;
        ext_test_done <= ext_test_start;
        ext_test_pass <= ext_test_start & et_ok;
        io_test_done <= io_test_start;
        go <= rst_b & (go | self_test_done);
    end
    // ==========================================================
    // Tasks
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        chk("rdata", bus_rdata, e);
    endtask
    task automatic pulse(input int s);
        case (s)
            0: console_boot_req <= 1'b1;
            1: nv_changed <= 1'b1;
            default: op_force_valid <= 1'b1;
        endcase
        @(posedge clk);
        {console_boot_req, nv_changed, op_force_valid} <= 3'b000;
        #1;
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: return start_line_in;
            1: return ext_test_start;
            2: return io_test_start;
            3: return console_prompt;
            4: return boot_start;
            default: return irq;
        endcase
    endfunction
    task automatic wait_on(input int s, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(posedge clk);
            #1;
            if (sig(s) === 1'b1)
                return;
        end
        failures++;
        $display("[ERR] wait %0d exp 1 seen 0", s);
        wrap_up();
    endtask
    task automatic power_up(input logic [3:0] n, input logic [15:0] s,
            input logic [15:0] e, input logic [15:0] l, input logic [2:0] f);
        rst_b <= 1'b0;
        node_id <= n;
        st_mask <= s;
        et_mask <= e;
        el_mask <= l;
        {st_ok, et_ok, auto_start_key} <= f;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
    endtask
    // ==========================================================
    // Scenarios
    initial begin
        // Node 2 wins: node 0 failed, node 1 ineligible even when named
        power_up(4'h2, 16'h0022, 16'h0022, 16'hfffd, 3'b110);
        rd(4'h0, 32'h1);
        rd(4'h2, 32'h0);
        wr(4'h0, 32'h13);
        wr(4'hc, 32'h2);
        wait_on(0, 200);
        chk("start_out", start_line_out, 1);
        wait_on(1, 3);
        rd(4'h4, 32'h00002a10);
        chk("irq_masked", irq, 0);
        wait_on(2, 200);
        wait_on(3, 10);
        chk("leds", {yellow_led, red_led, boot_choice_line_out,
            results_valid}, {1'b1, 8'hc0, 2'b11});
        chk("irq_final", irq, 1);
        rd(4'h8, 32'h3);
        rd(4'h4, 32'h00e52e80);
        wr(4'h8, 32'h3);
        chk("irq_clear", irq, 0);
        pulse(0);
        chk("boot_start", boot_start, 1);
        nv_hidden <= 1'b1;
        pulse(1);
        chk("nv_hidden", nv_copy_start, 0);
        nv_hidden <= 1'b0;
        pulse(1);
        chk("nv_copy", nv_copy_start, 1);
        rd(4'h8, 32'h10);
        $display("test own_boot done");
        // Node 1 is provisional, fails extended test, node 4 takes over
        power_up(4'h4, 16'h0042, 16'h0040, 16'hffff, 3'b111);
        wr(4'hc, 32'h4);
        wait_on(1, 300);
        wait_on(2, 200);
        wait_on(4, 20);
        chk("irq_resel", irq, 1);
        rd(4'h4, 32'h00e91e80);
        chk("leds", {yellow_led, red_led, boot_choice_line_out},
            {1'b1, 8'hc0, 1'b1});
        $display("test reselect done");
        // Nobody passes: hang, then operator forces node 0
        power_up(4'h0, 16'h0000, 16'h0000, 16'hffff, 3'b000);
        wr(4'hc, 32'h8);
        wait_on(5, 200);
        chk("hang_leds", {yellow_led, red_led, results_valid},
            {1'b0, 8'h42, 1'b0});
        pulse(2);
        repeat (8) @(posedge clk);
        #1;
        chk("early_force", console_prompt, 0);
        repeat (300) @(posedge clk);
        pulse(2);
        wait_on(3, 40);
        chk("forced_boot", boot_choice_line_out, 1);
        $display("test hang done");
        wrap_up();
    end
endmodule
